// >>> shared/dps_pkg.sv
package dps_pkg;
    // =====================================================
    // state and command encodings
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ACTIVE  = 3'b001,
        ST_BUSY    = 3'b010,
        ST_REFRESH = 3'b011,
        ST_PPD     = 3'b100,
        ST_APD     = 3'b101,
        ST_SREF    = 3'b110
    } dps_state_e;
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_REF = 3'b001,
        CMD_MRS = 3'b010,
        CMD_ACT = 3'b011,
        CMD_RD  = 3'b100,
        CMD_WR  = 3'b101,
        CMD_PRE = 3'b110,
        CMD_OTH = 3'b111
    } dps_cmd_e;
    // =====================================================
    // mode and timing constants
    localparam int          MR_DLL_OFF_BIT = 0;
    localparam logic [1:0]  MR1_SEL        = 2'h1;
    localparam logic [3:0]  DLL_OFF_CL     = 4'h6;
    localparam logic [3:0]  DLL_OFF_CWL    = 4'h6;
    localparam logic        DLL_OFF_RST    = 1'b0;
    localparam int          REF_BUSY_CYC   = 8;
    localparam int          BURST_CYC      = 4;
endpackage : dps_pkg

// >>> shared/dps_cmd_if.sv
interface dps_cmd_if;
    import dps_pkg::*;
    logic     cke;
    logic     ckePrev;
    dps_cmd_e cmd;
    logic     isNop;
    modport src (output cke, ckePrev, cmd, isNop);
    modport dst (input cke, ckePrev, cmd, isNop);
endinterface : dps_cmd_if

// >>> rtl/dps_cmd_decode.sv
module dps_cmd_decode
    import dps_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // pins
    input  wire logic ckePin,
    input  wire logic csN,
    input  wire logic rasN,
    input  wire logic casN,
    input  wire logic weN,
    // decoded
    dps_cmd_if.src    cmdOut
);
    import dps_pkg::*;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic       ckeD_r;
    logic [2:0] pinCode;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_r <= 5'h1F;
            sync2_r <= 5'h1F;
            ckeD_r  <= 1'b1;
        end else begin
            sync1_r <= {ckePin, csN, rasN, casN, weN};
            sync2_r <= sync1_r;
            ckeD_r  <= sync2_r[4];
        end
    end
    assign pinCode        = sync2_r[2:0];
    assign cmdOut.cke     = sync2_r[4];
    assign cmdOut.ckePrev = ckeD_r;
    // deselect or nop decode
    assign cmdOut.isNop   = sync2_r[3] || (pinCode == 3'h7);
    always_comb begin
        if (cmdOut.isNop) cmdOut.cmd = CMD_NOP;
        else begin
            unique case (pinCode)
                3'h0:    cmdOut.cmd = CMD_MRS;
                3'h1:    cmdOut.cmd = CMD_REF;
                3'h2:    cmdOut.cmd = CMD_PRE;
                3'h3:    cmdOut.cmd = CMD_ACT;
                3'h4:    cmdOut.cmd = CMD_WR;
                3'h5:    cmdOut.cmd = CMD_RD;
                3'h6:    cmdOut.cmd = CMD_OTH;
                default: cmdOut.cmd = CMD_NOP;
            endcase
        end
    end
endmodule : dps_cmd_decode

// >>> rtl/dps_power_state.sv
module dps_power_state
    import dps_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // command pins and side inputs
    input  wire logic       ckePin,
    input  wire logic       csN,
    input  wire logic       rasN,
    input  wire logic       casN,
    input  wire logic       weN,
    input  wire logic [1:0] mrSel,
    input  wire logic [3:0] mrData,
    input  wire logic       bankOpen,
    input  wire logic [3:0] casLat,
    input  wire logic [3:0] addLat,
    // status
    output dps_pkg::dps_state_e stateOut,
    output logic            dllOff,
    output logic            odtEnable,
    output logic            refreshActive,
    output logic [4:0]      strobeDelay,
    output logic            latencyOk
);
    import dps_pkg::*;
    dps_cmd_if cmdBus ();
    dps_cmd_decode uDec (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ckePin  (ckePin),
        .csN     (csN),
        .rasN    (rasN),
        .casN    (casN),
        .weN     (weN),
        .cmdOut  (cmdBus)
    );
    // =====================================================
    // synchronised side inputs
    logic [10:0] side1_r;
    logic [10:0] side2_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            side1_r <= 11'h000;
            side2_r <= 11'h000;
        end else begin
            side1_r <= {bankOpen, casLat, addLat, mrSel};
            side2_r <= side1_r;
        end
    end
    logic       bankOpenS;
    logic [3:0] clS;
    logic [3:0] alS;
    logic [1:0] mrSelS;
    assign {bankOpenS, clS, alS, mrSelS} = side2_r;
    logic [3:0] mrDat1_r;
    logic [3:0] mrDat2_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mrDat1_r <= 4'h0;
            mrDat2_r <= 4'h0;
        end else begin
            mrDat1_r <= mrData;
            mrDat2_r <= mrDat1_r;
        end
    end
    // =====================================================
    // transition decode
    dps_state_e state_r, state_nxt;
    logic [3:0] busy_r, busy_nxt;
    logic ckeFall, ckeRise, ckeLow;
    assign ckeFall = cmdBus.ckePrev && !cmdBus.cke;
    assign ckeRise = !cmdBus.ckePrev && cmdBus.cke;
    assign ckeLow  = !cmdBus.ckePrev && !cmdBus.cke;
    function automatic dps_state_e pdTarget(input logic open);
        return open ? ST_APD : ST_PPD;
    endfunction : pdTarget
    always_comb begin
        state_nxt = state_r;
        busy_nxt  = (busy_r != 4'h0) ? busy_r - 4'h1 : 4'h0;
        unique case (state_r)
            ST_PPD, ST_APD: begin
                if (ckeRise && cmdBus.isNop) state_nxt = bankOpenS ? ST_ACTIVE : ST_IDLE;
            end
            ST_SREF: begin
                if (cmdBus.cke) state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (ckeFall && cmdBus.cmd == CMD_REF) state_nxt = ST_SREF;
                else if (ckeFall && cmdBus.isNop) state_nxt = ST_PPD;
                else if (!ckeLow && cmdBus.cmd == CMD_REF) begin
                    state_nxt = ST_REFRESH;
                    busy_nxt  = 4'(REF_BUSY_CYC);
                end else if (cmdBus.cmd == CMD_ACT) state_nxt = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (ckeFall && cmdBus.isNop) state_nxt = ST_APD;
                else if (cmdBus.cmd inside {CMD_RD, CMD_WR, CMD_PRE}) begin
                    state_nxt = ST_BUSY;
                    busy_nxt  = 4'(BURST_CYC);
                end
            end
            ST_BUSY: begin
                if (ckeFall && cmdBus.isNop) state_nxt = pdTarget(bankOpenS);
                else if (busy_r == 4'h0) state_nxt = bankOpenS ? ST_ACTIVE : ST_IDLE;
            end
            ST_REFRESH: begin
                if (ckeFall && cmdBus.isNop) state_nxt = ST_PPD;
                else if (busy_r == 4'h0) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end
    // =====================================================
    // state and mode registers
    logic dllOff_r, dllOff_nxt;
    assign dllOff_nxt = (cmdBus.cmd == CMD_MRS && state_r == ST_IDLE && mrSelS == MR1_SEL)
                        ? mrDat2_r[MR_DLL_OFF_BIT] : dllOff_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r  <= ST_IDLE;
            busy_r   <= 4'h0;
            dllOff_r <= DLL_OFF_RST;
        end else begin
            state_r  <= state_nxt;
            busy_r   <= busy_nxt;
            dllOff_r <= dllOff_nxt;
        end
    end
    // =====================================================
    // outputs
    logic [4:0] latSum;
    assign latSum        = 5'(alS) + 5'(clS);
    assign stateOut      = state_r;
    assign dllOff        = dllOff_r;
    assign odtEnable     = (state_r != ST_SREF);
    assign refreshActive = (state_r == ST_REFRESH);
    assign latencyOk     = !dllOff_r || (clS == DLL_OFF_CL);
    logic [4:0] strobe_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) strobe_r <= 5'h00;
        else strobe_r <= dllOff_r ? latSum - 5'h01 : latSum;
    end
    assign strobeDelay = strobe_r;
    // =====================================================
    // checks
    AST_NO_REF_PD: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r inside {ST_PPD, ST_APD}) |-> !refreshActive)
        else $error("refresh while powered down");
    AST_SREF_ODT: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == ST_SREF) |-> !odtEnable)
        else $error("odt on in self refresh");
    AST_SREF_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == ST_IDLE && ckeFall && cmdBus.cmd == CMD_REF) |=> state_r == ST_SREF)
        else $error("self refresh not entered");
    AST_SREF_FROM_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
        ($rose(state_r == ST_SREF)) |-> $past(state_r) == ST_IDLE)
        else $error("self refresh from non idle");
    AST_APD_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == ST_ACTIVE && ckeFall && cmdBus.isNop) |=> state_r == ST_APD)
        else $error("active power down missed");
    AST_BUSY_PD: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == ST_BUSY && ckeFall && cmdBus.isNop) |=> state_r == (bankOpenS ? ST_APD : ST_PPD))
        else $error("wrong power down kind");
    AST_PD_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r inside {ST_PPD, ST_APD} && ckeLow) |=> state_r == $past(state_r))
        else $error("power down left on low cke");
    AST_STROBE: assert property (@(posedge clk_sys) disable iff (reset)
        dllOff_r |=> strobe_r == $past(latSum) - 5'h01)
        else $error("strobe reference wrong");
    AST_IDLE_CKE: assert property (@(posedge clk_sys) disable iff (reset)
        ($rose(state_r == ST_IDLE) && $past(state_r) inside {ST_PPD, ST_APD}) |-> $past(cmdBus.cke))
        else $error("idle with cke low");
endmodule : dps_power_state

// >>> testbench/dps_ctrl_model.sv
module dps_ctrl_model
    import dps_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // requests from bench
    input  wire logic       reqCke,
    input  wire logic       reqCsN,
    input  wire logic [2:0] reqCmd,
    // pins
    output logic            ckePin,
    output logic            csN,
    output logic            rasN,
    output logic            casN,
    output logic            weN
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================
    // command qualification on cke edges
    wire logic ckeEdge  = reqCke != ckePin;
    wire logic sreEntry = ckePin & ~reqCke & ~reqCsN & (reqCmd == 3'h1);
    wire logic forceDes = ckeEdge & ~sreEntry;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ckePin <= 1'b1;
            {csN, rasN, casN, weN} <= 4'hF;
        end else begin
            ckePin <= reqCke;
            csN    <= forceDes | reqCsN;
            {rasN, casN, weN} <= reqCmd;
        end
    end
endmodule : dps_ctrl_model

// >>> testbench/tb_dps_power_state.sv
module tb_dps_power_state;
    timeunit 1ns;
    timeprecision 1ps;
    import dps_pkg::*;
    logic       clk_sys = 1'b0, reset = 1'b1, reqCke = 1'b1, reqCsN = 1'b0, bankOpen = 1'b0;
    logic [2:0] reqCmd = 3'h7;
    logic [1:0] mrSel = 2'h0;
    logic [3:0] mrData = 4'h0, casLat = 4'h5, addLat = 4'h0;
    logic       ckePin, csN, rasN, casN, weN, dllOff, odtEnable, refreshActive, latencyOk;
    logic [4:0] strobeDelay;
    dps_state_e stateOut;
    int         err_total = 0, check_count = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    dps_ctrl_model dps_ctrl_model_inst (.clk_sys(clk_sys), .reset(reset), .reqCke(reqCke),
        .reqCsN(reqCsN), .reqCmd(reqCmd), .ckePin(ckePin), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN));
    dps_power_state dps_power_state_inst (.clk_sys(clk_sys), .reset(reset), .ckePin(ckePin), .csN(csN),
        .rasN(rasN), .casN(casN), .weN(weN), .mrSel(mrSel), .mrData(mrData), .bankOpen(bankOpen),
        .casLat(casLat), .addLat(addLat), .stateOut(stateOut), .dllOff(dllOff), .odtEnable(odtEnable),
        .refreshActive(refreshActive), .strobeDelay(strobeDelay), .latencyOk(latencyOk));
    // =====================================================
    // helpers
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task send(input logic cke, input logic cs, input logic [2:0] c);
        @(posedge clk_sys);
        reqCke <= cke;
        reqCsN <= cs;
        reqCmd <= c;
        @(posedge clk_sys);
        reqCsN <= 1'b0;
        reqCmd <= 3'h7;
    endtask : send
    task settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle
    task close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            close_out();
        end
    end
    // =====================================================
    // scenarios
    task t_reset;
        check(stateOut, ST_IDLE);
        check(dllOff, DLL_OFF_RST);
        check(odtEnable, 1'b1);
        check(strobeDelay, 5'h00);
        $display("reset test done");
    endtask : t_reset
    task t_active_pd;
        @(posedge clk_sys);
        bankOpen <= 1'b1;
        send(1'b1, 1'b0, 3'h3); settle(10);
        check(stateOut, ST_ACTIVE);
        send(1'b1, 1'b1, 3'h1); settle(10);
        check(stateOut, ST_ACTIVE);
        send(1'b0, 1'b1, 3'h7); settle(10);
        check(stateOut, ST_APD);
        send(1'b0, 1'b0, 3'h0); settle(10);
        check(stateOut, ST_APD);
        check(refreshActive, 1'b0);
        send(1'b1, 1'b0, 3'h7); settle(10);
        check(stateOut, ST_ACTIVE);
        @(posedge clk_sys);
        bankOpen <= 1'b0;
        send(1'b1, 1'b0, 3'h2); settle(12);
        check(stateOut, ST_IDLE);
        $display("active power-down test done");
    endtask : t_active_pd
    task t_burst_pd;
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_sys);
            bankOpen <= 1'b1;
            send(1'b1, 1'b0, 3'h3); settle(10);
            check(stateOut, ST_ACTIVE);
            @(posedge clk_sys);
            bankOpen <= b[0];
            settle(4);
            send(1'b1, 1'b0, 3'h5);
            send(1'b0, 1'b0, 3'h7); settle(12);
            check(stateOut, b[0] ? ST_APD : ST_PPD);
            check(refreshActive, 1'b0);
            send(1'b1, 1'b0, 3'h7); settle(10);
            check(stateOut, b[0] ? ST_ACTIVE : ST_IDLE);
            @(posedge clk_sys);
            bankOpen <= 1'b0;
            send(1'b1, 1'b0, 3'h2); settle(12);
            check(stateOut, ST_IDLE);
        end
        send(1'b0, 1'b0, 3'h7); settle(10);
        check(stateOut, ST_PPD);
        send(1'b1, 1'b0, 3'h7); settle(10);
        check(stateOut, ST_IDLE);
        $display("burst power-down test done");
    endtask : t_burst_pd
    task t_refresh;
        send(1'b1, 1'b0, 3'h1); settle(5);
        check(refreshActive, 1'b1);
        settle(14);
        check(stateOut, ST_IDLE);
        send(1'b0, 1'b0, 3'h1); settle(10);
        check(stateOut, ST_SREF);
        check(odtEnable, 1'b0);
        send(1'b0, 1'b0, 3'h3); settle(10);
        check(stateOut, ST_SREF);
        send(1'b1, 1'b0, 3'h7); settle(10);
        check(stateOut, ST_IDLE);
        check(odtEnable, 1'b1);
        $display("refresh test done");
    endtask : t_refresh
    task t_dll;
        @(posedge clk_sys);
        mrSel <= 2'h2; mrData <= 4'h1; casLat <= 4'h6; addLat <= 4'h0;
        settle(4);
        send(1'b1, 1'b0, 3'h0); settle(10);
        check(dllOff, 1'b0);
        check(strobeDelay, 5'h06);
        @(posedge clk_sys);
        mrSel <= MR1_SEL;
        settle(4);
        send(1'b1, 1'b0, 3'h0); settle(10);
        check(dllOff, 1'b1);
        check(strobeDelay, 5'h05);
        check(latencyOk, 1'b1);
        @(posedge clk_sys);
        casLat <= 4'h7; addLat <= 4'h2; settle(10);
        check(latencyOk, 1'b0);
        check(strobeDelay, 5'h08);
        @(posedge clk_sys);
        mrData <= 4'h0; settle(4);
        send(1'b1, 1'b0, 3'h0); settle(10);
        check(dllOff, 1'b0);
        check(strobeDelay, 5'h09);
        check(latencyOk, 1'b1);
        $display("delay loop test done");
    endtask : t_dll
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        settle(2);
        t_reset();
        t_active_pd();
        t_burst_pd();
        t_refresh();
        t_dll();
        close_out();
    end
endmodule : tb_dps_power_state
